// *** src/prh_consts.vh ***
// Purpose: constants of the privileged return and hazard control block
// Assumes: included by bare name from the design files
// Notes: register indices are word indices on the plain register port
`ifndef PRH_CONSTS_VH
`define PRH_CONSTS_VH

// instruction encodings and masks
`define PRH_EHB_WORD 32'h0000_00C0
`define PRH_SUPERSCALAR_NOP_OP_WORD 32'h0000_0040
`define PRH_EI_MASK 32'hFFE0_FFFF
`define PRH_EI_WORD 32'h4160_6020
`define PRH_EXCEPTION_RETURN_OP_WORD 32'h4200_0018
`define PRH_HBJ_MASK 32'hFC1F_043E
`define PRH_HBJ_WORD 32'h0000_0408
`define PRH_RT_HI 20
`define PRH_RT_LO 16

// status bit positions
`define PRH_ST_IE 0
`define PRH_ST_EXL 1
`define PRH_ST_ERL 2
`define PRH_ST_BEV 22

// exception codes raised towards the pipeline
`define PRH_EXC_RI 5'h0A
`define PRH_EXC_CPU 5'h0B

// hazard drain time and its cycle count at 20 MHz
`define PRH_CLK_MHZ 20
`define PRH_DRAIN_NS 100
`define PRH_DRAIN_CYC ((`PRH_DRAIN_NS * `PRH_CLK_MHZ + 999) / 1000)

// register indices
`define PRH_REG_EVT 4'h0
`define PRH_REG_MASK 4'h1
`define PRH_REG_CTRL 4'h2
`define PRH_REG_STATE 4'h3

// event bits
`define PRH_EV_EHB 0
`define PRH_EV_EI 1
`define PRH_EV_EXCEPTION_RETURN_OP 2
`define PRH_EV_EXC 3
`define PRH_EV_W 4

// control bits and reset value
`define PRH_CT_REV2 0
`define PRH_CT_SHADOW 1
`define PRH_CT_COMPR 2
`define PRH_CTRL_RST 3'h3

`endif

// *** src/prh_decode.v ***
// Purpose: recognise the privileged and barrier instruction words
// Assumes: a 32-bit instruction word, combinational use
// Notes: all outputs are pure functions of the word
`timescale 1ns/1ps
`include "prh_consts.vh"
module prh_decode (
  input wire [31:0] instr,
  output wire isEhb,
  output wire isSsnop,
  output wire isEi,
  output wire isEret,
  output wire isHbJump,
  output wire [4:0] destGpr
);
  // barrier is the shift of the zero register into itself by 3
  assign isEhb = (instr == `PRH_EHB_WORD); // see RULE1
  assign isSsnop = (instr == `PRH_SUPERSCALAR_NOP_OP_WORD);
  assign isEi = ((instr & `PRH_EI_MASK) == `PRH_EI_WORD);
  // cp0 major opcode, operation bit, zero middle, return function
  assign isEret = (instr == `PRH_EXCEPTION_RETURN_OP_WORD); // see RULE19
  // register jumps with the hazard hint bit set
  assign isHbJump = ((instr & `PRH_HBJ_MASK) == `PRH_HBJ_WORD); // see RULE3
  assign destGpr = instr[`PRH_RT_HI:`PRH_RT_LO];
endmodule // prh_decode

// *** src/prh_hazwait.v ***
// Purpose: hold a barrier until a hazard source has drained
// Assumes: pending is high while earlier hazards are outstanding
// Notes: waits at least the drain count, then for pending low
`timescale 1ns/1ps
`include "prh_consts.vh"
module prh_hazwait (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire pending,
  output reg busy_q,
  output reg done_q
);
  localparam integer DRAIN_INT = `PRH_DRAIN_CYC;
  localparam [3:0] DRAIN = DRAIN_INT[3:0];
  reg [3:0] cnt_q;

  // minimum drain count, then wait for the source to clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        cnt_q <= DRAIN;
      end
      else if (busy_q)
      begin
        if (cnt_q != 4'h0)
          cnt_q <= cnt_q - 4'h1;
        else if (!pending)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // prh_hazwait

// *** src/prh_ctl.v ***
// Purpose: barrier, interrupt-enable and exception-return control
// Assumes: one instruction offered per cycle; issueStall_q holds it
// Notes: registers on a plain port, read data one cycle after read
// Summary of operation
// RULE1 - barrier decoded as zero-register shift left by three, otherwise a no-op
// RULE2 - barrier holds issue until earlier execution hazards clear, even in slot
// RULE3 - barrier does not clear instruction hazards; hb jumps and return do; here hb jumps start no drain, only latch the enable
// RULE4 - first revision runs the barrier exactly as a superscalar no-op
// RULE5 - enable op writes sign-extended status to destination, then sets enable
// RULE6 - zero-register destination discards old status, only sets enable
// RULE7 - enable op without cp0 access raises unusable, changes nothing
// RULE8 - first revision raises reserved instruction for the enable op
// RULE9 - status read and enable set happen as one indivisible step
// RULE10 - enable change takes effect only at barrier, hb jump or return
// RULE11 - return has no delay slot; next word squashed, fetch redirected
// RULE12 - error level set: error address, clear it; else normal, clear exl
// RULE13 - rev2 normal path with shadows copies previous set unless bev or erl
// RULE14 - return clears the link reservation flag
// RULE15 - return clears execution and instruction hazards before target fetch
// RULE16 - software never puts a return in a delay slot; result undefined
// RULE17 - compressed mode: pc from bits 63..1, isa mode from bit 0
// RULE18 - return without cp0 access raises unusable, pc and status kept
// RULE19 - return decoded from cp0 opcode, operation bit, zeros, function
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "prh_consts.vh"
module prh_ctl (
  input wire clk,
  input wire rst_n,
  input wire issueValid,
  input wire [31:0] issueInstr,
  input wire inDelaySlot,
  input wire cp0Usable,
  input wire execHazard,
  input wire instrHazard,
  input wire excEnter,
  input wire errEnter,
  input wire llSet,
  input wire bevIn,
  input wire [31:0] statusIn,
  input wire [3:0] pssIn,
  input wire [3:0] hssIn,
  input wire [63:0] epcIn,
  input wire [63:0] errorEpcIn,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWe,
  input wire regRe,
  output reg [31:0] regRdata_q,
  output reg issueStall_q,
  output reg squashNext_q,
  output reg gprWe_q,
  output reg [4:0] gprAddr_q,
  output reg [63:0] gprData_q,
  output reg excValid_q,
  output reg [4:0] excCode_q,
  output reg redirect_q,
  output reg [63:0] redirectPc_q,
  output reg isa_mode_select_q,
  output reg statusIe_q,
  output reg statusExl_q,
  output reg statusErl_q,
  output reg intEnableEff_q,
  output reg [3:0] css_q,
  output reg linkFlag_q,
  output reg irq_q
);
  // sequencer states: idle, barrier drain, return drain
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_EHB = 2'd1;
  localparam [1:0] ST_EXCEPTION_RETURN_OP = 2'd2;

  // sequencer, register-port storage and the pending return target
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`PRH_EV_W-1:0] evt_q;
  reg [`PRH_EV_W-1:0] mask_q;
  reg [2:0] ctrl_q;
  reg [63:0] retPc_q;
  reg retIsa_q;
  reg [`PRH_EV_W-1:0] evSet;
  // decoded word, drain status and per-instruction qualifiers
  wire isEhb;
  wire isEi;
  wire isEret;
  wire isHbJump;
  wire [4:0] destGpr;
  wire exBusy;
  wire inBusy;
  wire take;
  wire rev2;
  wire [31:0] statusView;
  wire [63:0] retAddr;
  wire eiGo;
  wire eretGo;
  wire ehbGo;
  wire eiRi;
  wire eiCpu;
  wire eretCpu;
  wire eretEnd;
  wire ehbEnd;

  // one decoder; the plain superscalar no-op needs no handling here
  prh_decode u_dec (
    .instr(issueInstr),
    .isEhb(isEhb),
    .isSsnop(),
    .isEi(isEi),
    .isEret(isEret),
    .isHbJump(isHbJump),
    .destGpr(destGpr)
  );

  // execution hazard drain, used by barrier and return
  prh_hazwait u_exw (
    .clk(clk),
    .rst_n(rst_n),
    .start(ehbGo | eretGo),
    .pending(execHazard),
    .busy_q(exBusy),
    .done_q()
  );

  // instruction hazard drain, used only by return
  prh_hazwait u_inw (
    .clk(clk),
    .rst_n(rst_n),
    .start(eretGo),
    .pending(instrHazard),
    .busy_q(inBusy),
    .done_q()
  );

  // instruction accepted when offered and not stalled
  assign take = issueValid & ~issueStall_q;
  assign rev2 = ctrl_q[`PRH_CT_REV2];

  // status as software sees it, with the bits this block owns
  assign statusView = {statusIn[31:23], bevIn, statusIn[21:3],
    statusErl_q, statusExl_q, statusIe_q};

  // classify the accepted instruction
  // a refused word raises its exception and moves nothing else
  assign eiRi = take & isEi & ~rev2; // see RULE8
  assign eiCpu = take & isEi & rev2 & ~cp0Usable; // see RULE7
  assign eiGo = take & isEi & rev2 & cp0Usable;
  assign eretCpu = take & isEret & ~cp0Usable; // see RULE18
  // a return in a delay slot is undefined; it is handled as usual
  assign eretGo = take & isEret & cp0Usable; // see RULE16
  // first revision: barrier is a plain superscalar no-op
  assign ehbGo = take & isEhb & rev2; // see RULE4
  // a drain ends once every source it waits on is quiet
  assign ehbEnd = (state_q == ST_EHB) & ~exBusy;
  assign eretEnd = (state_q == ST_EXCEPTION_RETURN_OP) & ~exBusy & ~inBusy;

  // error level chooses which saved address the return uses
  assign retAddr = statusErl_q ? errorEpcIn : epcIn; // see RULE12

  // barrier and return sequencing
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (ehbGo)
          state_d = ST_EHB; // see RULE2
        else if (eretGo)
          state_d = ST_EXCEPTION_RETURN_OP; // see RULE15
      end
      ST_EHB:
      begin
        if (ehbEnd)
          state_d = ST_IDLE;
      end
      ST_EXCEPTION_RETURN_OP:
      begin
        if (eretEnd)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // events that feed the sticky status register
  always @*
  begin
    evSet = {`PRH_EV_W{1'b0}};
    evSet[`PRH_EV_EHB] = (state_q == ST_EHB) & ehbEnd;
    evSet[`PRH_EV_EI] = eiGo;
    evSet[`PRH_EV_EXCEPTION_RETURN_OP] = (state_q == ST_EXCEPTION_RETURN_OP) & eretEnd;
    evSet[`PRH_EV_EXC] = eiRi | eiCpu | eretCpu;
  end

  // pipeline control, state machine and stall
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      issueStall_q <= 1'b0;
      squashNext_q <= 1'b0;
      excValid_q <= 1'b0;
      excCode_q <= 5'h00;
      redirect_q <= 1'b0;
      redirectPc_q <= 64'h0000_0000_0000_0000;
      isa_mode_select_q <= 1'b0;
      retPc_q <= 64'h0000_0000_0000_0000;
      retIsa_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // hold issue from the accept until the drain finishes
      issueStall_q <= (state_d != ST_IDLE); // see RULE2
      squashNext_q <= eretGo; // see RULE11
      // one-cycle exception pulse, code held until the next one
      excValid_q <= eiRi | eiCpu | eretCpu;
      if (eiRi)
        excCode_q <= `PRH_EXC_RI;
      else if (eiCpu | eretCpu)
        excCode_q <= `PRH_EXC_CPU;
      redirect_q <= (state_q == ST_EXCEPTION_RETURN_OP) & eretEnd; // see RULE11
      // target captured at accept, so later level changes cannot move it
      if (eretGo)
      begin
        // compressed mode splits the address into pc and isa mode
        if (ctrl_q[`PRH_CT_COMPR])
        begin
          retPc_q <= {1'b0, retAddr[63:1]}; // see RULE17
          retIsa_q <= retAddr[0]; // see RULE17
        end
        else
        begin
          retPc_q <= retAddr; // see RULE17
          retIsa_q <= isa_mode_select_q;
        end
      end
      // new pc and redirect pulse appear together when the drain ends
      if ((state_q == ST_EXCEPTION_RETURN_OP) & eretEnd)
      begin
        redirectPc_q <= retPc_q;
        isa_mode_select_q <= retIsa_q;
      end
    end
  end

  // status bits, shadow set, link flag and destination write
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      statusIe_q <= 1'b0;
      statusExl_q <= 1'b0;
      statusErl_q <= 1'b1;
      css_q <= 4'h0;
      linkFlag_q <= 1'b0;
      gprWe_q <= 1'b0;
      gprAddr_q <= 5'h00;
      gprData_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      // old status and new enable in one update, nothing in between
      gprWe_q <= eiGo & (destGpr != 5'h00); // see RULE6
      if (eiGo)
      begin
        gprAddr_q <= destGpr;
        gprData_q <= {{32{statusView[31]}}, statusView}; // see RULE5
        statusIe_q <= 1'b1; // see RULE9
      end
      // return clears one level flag; entry sets win over the clear
      if (eretGo & statusErl_q)
        statusErl_q <= errEnter; // see RULE12
      else if (errEnter)
        statusErl_q <= 1'b1;
      if (eretGo & ~statusErl_q)
        statusExl_q <= excEnter; // see RULE12
      else if (excEnter)
        statusExl_q <= 1'b1;
      // shadow copy only on the normal path of a shadowed rev2 part
      if (eretGo & ~statusErl_q & rev2 & ctrl_q[`PRH_CT_SHADOW] &
          (hssIn != 4'h0) & ~bevIn)
        css_q <= pssIn; // see RULE13
      // reservation dropped by the return; a new link set wins
      if (llSet)
        linkFlag_q <= 1'b1;
      else if (eretGo)
        linkFlag_q <= 1'b0; // see RULE14
    end
  end

  // the effective enable follows status only at hazard-clearing points
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      intEnableEff_q <= 1'b0;
    else if (((state_q == ST_EHB) & ehbEnd) | (take & isHbJump) |
             ((state_q == ST_EXCEPTION_RETURN_OP) & eretEnd))
      intEnableEff_q <= statusIe_q; // see RULE10
  end

  // register port: sticky events, mask, control, read data
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_q <= {`PRH_EV_W{1'b0}};
      mask_q <= {`PRH_EV_W{1'b0}};
      ctrl_q <= `PRH_CTRL_RST;
      regRdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end
    else
    begin
      // write one clears, a new event in the same cycle wins
      if (regWe & (regAddr == `PRH_REG_EVT))
        evt_q <= (evt_q & ~regWdata[`PRH_EV_W-1:0]) | evSet;
      else
        evt_q <= evt_q | evSet;
      if (regWe & (regAddr == `PRH_REG_MASK))
        mask_q <= regWdata[`PRH_EV_W-1:0];
      if (regWe & (regAddr == `PRH_REG_CTRL))
        ctrl_q <= regWdata[2:0];
      // level interrupt lags the sticky bits by one cycle
      irq_q <= |(evt_q & mask_q);
      // read data stand only in the cycle after the strobe
      if (regRe)
      begin
        case (regAddr)
          `PRH_REG_EVT:
            regRdata_q <= {28'h000_0000, evt_q};
          `PRH_REG_MASK:
            regRdata_q <= {28'h000_0000, mask_q};
          `PRH_REG_CTRL:
            regRdata_q <= {29'h0000_0000, ctrl_q};
          `PRH_REG_STATE:
            regRdata_q <= {19'h0_0000, css_q, linkFlag_q, intEnableEff_q,
              statusErl_q, statusExl_q, statusIe_q, inDelaySlot, 1'b0,
              state_q}; // bit 2 reads zero
          default:
            regRdata_q <= 32'h0000_0000;
        endcase
      end
      else
        regRdata_q <= 32'h0000_0000;
    end
  end
endmodule // prh_ctl

// *** verif/prh_ctl_sva.sv ***
// Purpose: port-level checks of the barrier, enable and return control
// Assumes: one clock domain, async active-low reset
// Notes: bound to every prh_ctl instance
`timescale 1ns/1ps
`include "prh_consts.vh"
module prh_ctl_sva (
  input wire clk,
  input wire rst_n,
  input wire issueValid,
  input wire [31:0] issueInstr,
  input wire cp0Usable,
  input wire execHazard,
  input wire instrHazard,
  input wire issueStall_q,
  input wire squashNext_q,
  input wire gprWe_q,
  input wire [4:0] gprAddr_q,
  input wire excValid_q,
  input wire [4:0] excCode_q,
  input wire redirect_q,
  input wire statusIe_q,
  input wire statusExl_q,
  input wire statusErl_q,
  input wire intEnableEff_q,
  input wire linkFlag_q
);
  // decode of the word taken at this edge
  wire takeW = issueValid && !issueStall_q;
  wire takeRet = takeW && issueInstr == `PRH_EXCEPTION_RETURN_OP_WORD;
  wire takeEn = takeW && (issueInstr & `PRH_EI_MASK) == `PRH_EI_WORD;
  wire takeHb = takeW && (issueInstr & `PRH_HBJ_MASK) == `PRH_HBJ_WORD;
  wire [4:0] dst = issueInstr[`PRH_RT_HI:`PRH_RT_LO];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_stall_hazard: assert property (issueStall_q && execHazard |=>
    issueStall_q) else $error("stall dropped with hazard pending");
  a_redir_clean: assert property (execHazard || instrHazard |=>
    !redirect_q) else $error("redirect before hazards drained");
  a_ret_squash: assert property (takeRet && cp0Usable |=> squashNext_q &&
    issueStall_q) else $error("return word not squashed");
  a_ret_errlvl: assert property (takeRet && cp0Usable && statusErl_q |=>
    !statusErl_q) else $error("error level kept");
  a_ret_exclvl: assert property (takeRet && cp0Usable && !statusErl_q |=>
    !statusExl_q) else $error("exception level kept");
  a_ret_link: assert property (takeRet && cp0Usable |=> !linkFlag_q)
    else $error("link flag kept");
  a_ret_nocp: assert property (takeRet && !cp0Usable |=> excValid_q &&
    excCode_q == `PRH_EXC_CPU && !squashNext_q)
    else $error("return without access");
  a_en_write: assert property (takeEn && cp0Usable && dst != 5'h00 |=>
    (gprWe_q && gprAddr_q == $past(dst)) ||
    (excValid_q && excCode_q == `PRH_EXC_RI))
    else $error("enable result missing");
  a_en_zero: assert property (takeEn && dst == 5'h00 |=> !gprWe_q)
    else $error("zero destination written");
  a_en_nocp: assert property (takeEn && !cp0Usable |=> excValid_q &&
    excCode_q == `PRH_EXC_CPU && !gprWe_q && statusIe_q == $past(statusIe_q))
    else $error("enable without access");
  a_ie_late: assert property ($changed(intEnableEff_q) |->
    $fell(issueStall_q) || $past(takeHb))
    else $error("enable effect too early");
  c_ret: cover property (takeRet && cp0Usable);
  c_en: cover property (takeEn && cp0Usable);
  c_stall: cover property (issueStall_q && execHazard);
endmodule // prh_ctl_sva

bind prh_ctl prh_ctl_sva u_sva (
  .clk(clk), .rst_n(rst_n), .issueValid(issueValid),
  .issueInstr(issueInstr), .cp0Usable(cp0Usable),
  .execHazard(execHazard), .instrHazard(instrHazard),
  .issueStall_q(issueStall_q), .squashNext_q(squashNext_q),
  .gprWe_q(gprWe_q), .gprAddr_q(gprAddr_q), .excValid_q(excValid_q),
  .excCode_q(excCode_q), .redirect_q(redirect_q), .statusIe_q(statusIe_q),
  .statusExl_q(statusExl_q), .statusErl_q(statusErl_q),
  .intEnableEff_q(intEnableEff_q), .linkFlag_q(linkFlag_q)
);

// *** verif/prh_pipe_model.sv ***
// Purpose: issue-side pipeline that offers words and raises hazards
// Assumes: go is a one-cycle request with word and hazLen beside it
// Notes: instruction hazards last twice as long as execution hazards
`timescale 1ns/1ps
module prh_pipe_model (
  input wire clk,
  input wire rst_n,
  input wire issueStall,
  input wire go,
  input wire [31:0] word,
  input wire [3:0] hazLen,
  output reg issueValid,
  output reg [31:0] issueInstr,
  output wire execHazard,
  output wire instrHazard
);
  reg [3:0] hx_q;
  reg [4:0] hi_q;
  assign execHazard = hx_q != 4'h0;
  assign instrHazard = hi_q != 5'h00;
  // hold the word until taken, then show a changed pattern
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      issueValid <= 1'b0;
      issueInstr <= 32'h0000_0000;
      hx_q <= 4'h0;
      hi_q <= 5'h00;
    end
    else
    begin
      if (go)
      begin
        issueValid <= 1'b1;
        issueInstr <= word;
        hx_q <= hazLen;
        hi_q <= {hazLen, 1'b0};
      end
      else
      begin
        if (issueValid && !issueStall)
        begin
          issueValid <= 1'b0;
          issueInstr <= ~issueInstr;
        end
        if (hx_q != 4'h0)
          hx_q <= hx_q - 4'h1;
        if (hi_q != 5'h00)
          hi_q <= hi_q - 5'h01;
      end
    end
  end
endmodule // prh_pipe_model

// *** verif/prh_ctl_tb.sv ***
// Purpose: self-checking bench of the privileged control block
// Assumes: 20 MHz clock, registers on the plain port
// Notes: random status, addresses and destinations from a fixed seed
`timescale 1ns/1ps
`include "prh_consts.vh"
module prh_ctl_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg inDelaySlot = 0, cp0Usable = 1, excEnter = 0, errEnter = 0;
  reg llSet = 0, bevIn = 0, regWe = 0, regRe = 0, go = 0;
  reg [31:0] statusIn = 0, regWdata = 0, word = 0, rdv, rnd;
  reg [3:0] pssIn = 0, hssIn = 4'h3, regAddr = 0, hazLen = 0, pOld;
  reg [63:0] epcIn = 0, errorEpcIn = 0, gD;
  reg [4:0] gA, eC, dst;
  wire issueValid, execHazard, instrHazard, issueStall_q, squashNext_q;
  wire gprWe_q, excValid_q, redirect_q, isa_mode_select_q, statusIe_q;
  wire statusExl_q, statusErl_q, intEnableEff_q, linkFlag_q, irq_q;
  wire [31:0] issueInstr, regRdata_q;
  wire [4:0] gprAddr_q, excCode_q;
  wire [63:0] gprData_q, redirectPc_q;
  wire [3:0] css_q;
  integer errors = 0, numChecks = 0, nG = 0, nE = 0, nR = 0, nS = 0;
  integer nSt = 0, i, gB, eB, rB, sB, tB;

  prh_ctl u_dut (.clk(clk), .rst_n(rst_n), .issueValid(issueValid),
    .issueInstr(issueInstr), .inDelaySlot(inDelaySlot),
    .cp0Usable(cp0Usable), .execHazard(execHazard),
    .instrHazard(instrHazard), .excEnter(excEnter), .errEnter(errEnter),
    .llSet(llSet), .bevIn(bevIn), .statusIn(statusIn), .pssIn(pssIn),
    .hssIn(hssIn), .epcIn(epcIn), .errorEpcIn(errorEpcIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata_q(regRdata_q), .issueStall_q(issueStall_q),
    .squashNext_q(squashNext_q), .gprWe_q(gprWe_q), .gprAddr_q(gprAddr_q),
    .gprData_q(gprData_q), .excValid_q(excValid_q), .excCode_q(excCode_q),
    .redirect_q(redirect_q), .redirectPc_q(redirectPc_q),
    .isa_mode_select_q(isa_mode_select_q), .statusIe_q(statusIe_q),
    .statusExl_q(statusExl_q), .statusErl_q(statusErl_q),
    .intEnableEff_q(intEnableEff_q), .css_q(css_q),
    .linkFlag_q(linkFlag_q), .irq_q(irq_q));
  prh_pipe_model u_pipe (.clk(clk), .rst_n(rst_n),
    .issueStall(issueStall_q), .go(go), .word(word), .hazLen(hazLen),
    .issueValid(issueValid), .issueInstr(issueInstr),
    .execHazard(execHazard), .instrHazard(instrHazard));

  always #25 clk = ~clk;

  // count pulses and stall cycles, keep what the pulses carried
  always @(posedge clk)
  begin
    if (gprWe_q === 1'b1)
    begin
      nG = nG + 1;
      gA = gprAddr_q;
      gD = gprData_q;
    end
    if (excValid_q === 1'b1)
    begin
      nE = nE + 1;
      eC = excCode_q;
    end
    if (redirect_q === 1'b1)
      nR = nR + 1;
    if (squashNext_q === 1'b1)
      nS = nS + 1;
    if (issueStall_q === 1'b1)
      nSt = nSt + 1;
  end

  // status as read back: level and enable bits are the block's own
  function [63:0] sx(input [31:0] s, input b, e2, e1, i0);
    reg [31:0] v;
    begin
      v = s;
      v[`PRH_ST_BEV] = b;
      v[`PRH_ST_ERL] = e2;
      v[`PRH_ST_EXL] = e1;
      v[`PRH_ST_IE] = i0;
      sx = {{32{v[31]}}, v};
    end
  endfunction

  function [31:0] wEn(input [4:0] d);
    wEn = `PRH_EI_WORD | {11'h000, d, 16'h0000};
  endfunction

  task final_report;
    begin
      if (errors == 0 && numChecks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [63:0] got, input [63:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWe <= 1'b1;
      @(posedge clk);
      regWe <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regRe <= 1'b1;
      @(posedge clk);
      regRe <= 1'b0;
      @(posedge clk);
      d = regRdata_q;
    end
  endtask

  // pulse the entry and load-linked inputs as {err, exc, link}
  task pul(input [2:0] m);
    begin
      @(posedge clk);
      {errEnter, excEnter, llSet} <= m;
      @(posedge clk);
      {errEnter, excEnter, llSet} <= 3'h0;
    end
  endtask

  // offer one word, wait until taken and any stall is over
  task op(input [31:0] w, input [3:0] h);
    begin
      gB = nG;
      eB = nE;
      rB = nR;
      sB = nS;
      tB = nSt;
      @(posedge clk);
      go <= 1'b1;
      word <= w;
      hazLen <= h;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      for (i = 0; i < 60 && (issueValid !== 1'b0 ||
           issueStall_q !== 1'b0); i = i + 1)
        @(negedge clk);
      if (i == 60)
        chk(1, 0);
      repeat (2) @(posedge clk);
    end
  endtask

  // give up if the sequence hangs
  initial
  begin
    #500000;
    errors = errors + 1;
    final_report;
  end

  // main sequence
  initial
  begin
    rnd = $urandom(32'h4815);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(statusErl_q, 1);
    rd(`PRH_REG_CTRL, rdv);
    chk(rdv, 3);
    rd(4'hF, rdv);
    chk(rdv, 0);
    rnd = $urandom;
    statusIn <= $urandom;
    epcIn <= {$urandom, $urandom};
    errorEpcIn <= {$urandom, $urandom};
    pssIn <= rnd[3:0] | 4'h1;
    dst = rnd[8:4] | 5'h01;
    cp0Usable <= 1'b0;
    op(wEn(dst), 4'h0);
    chk(eC, `PRH_EXC_CPU);
    chk(nG - gB, 0);
    chk(nE - eB, 1);
    chk(statusIe_q, 0);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h0);
    chk(eC, `PRH_EXC_CPU);
    chk(nR - rB, 0);
    chk(nE - eB, 1);
    chk(statusErl_q, 1);
    cp0Usable <= 1'b1;
    op(wEn(dst), 4'h0);
    chk(gA, dst);
    chk(gD, sx(statusIn, 0, 1, 0, 0));
    chk(statusIe_q, 1);
    chk(intEnableEff_q, 0);
    op(wEn(5'h00), 4'h0);
    chk(nG - gB, 0);
    inDelaySlot <= 1'b1;
    op(`PRH_EHB_WORD, 4'h8);
    chk(nSt - tB > 5, 1);
    chk(intEnableEff_q, 1);
    chk(instrHazard, 1);
    inDelaySlot <= 1'b0;
    op(`PRH_SUPERSCALAR_NOP_OP_WORD, 4'h0);
    chk(nSt - tB, 0);
    op(32'h0000_0080, 4'h4);
    chk(nSt - tB, 0);
    pul(3'h1);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h3);
    chk(redirectPc_q, errorEpcIn);
    chk(statusErl_q, 0);
    chk(nS - sB, 1);
    chk(nR - rB, 1);
    chk(linkFlag_q, 0);
    chk(css_q, 0);
    pul(3'h2);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h5);
    chk(redirectPc_q, epcIn);
    chk(statusExl_q, 0);
    chk(css_q, pssIn);
    pOld = pssIn;
    bevIn <= 1'b1;
    pssIn <= ~pssIn;
    pul(3'h2);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h0);
    chk(css_q, pOld);
    bevIn <= 1'b0;
    wr(`PRH_REG_CTRL, 32'h0000_0007);
    pul(3'h2);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h0);
    chk(redirectPc_q, {1'b0, epcIn[63:1]});
    chk(isa_mode_select_q, epcIn[0]);
    pOld = pssIn;
    pssIn <= ~pssIn;
    hssIn <= 4'h0;
    pul(3'h2);
    op(`PRH_EXCEPTION_RETURN_OP_WORD, 4'h0);
    chk(css_q, pOld);
    wr(`PRH_REG_CTRL, 32'h0000_0000);
    wr(`PRH_REG_EVT, 32'h0000_001F);
    wr(`PRH_REG_MASK, 32'h0000_0008);
    rd(`PRH_REG_EVT, rdv);
    chk(rdv, 0);
    chk(irq_q, 0);
    op(wEn(dst), 4'h0);
    chk(eC, `PRH_EXC_RI);
    chk(nG - gB, 0);
    chk(nE - eB, 1);
    chk(irq_q, 1);
    op(`PRH_EHB_WORD, 4'h6);
    chk(nSt - tB, 0);
    rd(`PRH_REG_EVT, rdv);
    chk(rdv & 32'h0000_0008, 32'h0000_0008);
    wr(`PRH_REG_MASK, 32'h0000_0000);
    repeat (2) @(negedge clk);
    chk(irq_q, 0);
    wr(`PRH_REG_MASK, 32'h0000_0008);
    wr(`PRH_REG_EVT, 32'h0000_0008);
    repeat (2) @(negedge clk);
    chk(irq_q, 0);
    // second reset in mid-run, then a hazard-clearing jump
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(statusErl_q, 1);
    chk(intEnableEff_q, 0);
    op(wEn(5'h00), 4'h0);
    chk(intEnableEff_q, 0);
    op(32'h0200_0408, 4'h0);
    chk(intEnableEff_q, 1);
    final_report;
  end
endmodule // prh_ctl_tb
